// *** logic/cor_regs.vh ***
// Purpose: register map, field positions, reset values and timing for the output routing block
// Assumes: 32-bit AXI4-Lite register bus, 50 MHz clock
// Notes:   byte addresses, each register one aligned word
`ifndef COR_REGS_VH
`define COR_REGS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define COR_CFG_OFF      8'h00
`define COR_INV_OFF      8'h04
`define COR_ASG0_OFF     8'h08
`define COR_ASG1_OFF     8'h0C
`define COR_ASG2_OFF     8'h10
`define COR_ASG3_OFF     8'h14
`define COR_CMD_OFF      8'h18
`define COR_VAL1_OFF     8'h1C
`define COR_VAL2_OFF     8'h20
`define COR_HOSTBO_OFF   8'h24
`define COR_STAT_OFF     8'h28

// ----------------------------------------
// configuration fields
// ----------------------------------------
`define COR_TYPE_LSB     0
`define COR_STR1_LSB     4
`define COR_STR2_LSB     6
`define COR_DEPTH_LSB    8
`define COR_LOCK_LSB     11
`define COR_SLOT5_LSB    14
`define COR_SLOT6_LSB    16
`define COR_MPRIO1_BIT   18
`define COR_MPRIO2_BIT   19
`define COR_REV1_BIT     20
`define COR_REV2_BIT     21
`define COR_CFG_RST      32'h0000_2000
`define COR_TYPE_DUAL    4'hC
`define COR_DEPTH_HOST   3'h2
`define COR_LOCK_RC      3'h3
`define COR_SLOT_NONE    2'h0
`define COR_SLOT_FOUR    2'h1
`define COR_SLOT_TWO     2'h2

// ----------------------------------------
// timing
// ----------------------------------------
`define COR_CLK_MHZ      50
`define COR_TICK_US      1000
`define COR_WARN_MS      3000

`endif

// *** logic/cor_msg_route.v ***
// Purpose: invert and route message signals onto binary outputs, OR-merging shared outputs
// Assumes: assignment field value k (1..NOUT) selects output k, 0 leaves the message unrouted
// Notes:   purely combinational, the caller registers the result
`timescale 1ns/1ps
module cor_msg_route #(
  parameter NMSG = 16,
  parameter NOUT = 16,
  parameter AW   = 5
) (
  input  wire [NMSG-1:0]    msg,      // message signals, active high
  input  wire [NMSG-1:0]    invMask,  // per-message negation
  input  wire [NMSG*AW-1:0] asgFlat,  // per-message output number
  output wire [NOUT-1:0]    routed,   // merged outputs
  output wire [NOUT-1:0]    assigned  // output has at least one message
);

  wire [NMSG-1:0] msgPol = msg ^ invMask;

  genvar j;
  generate
    for (j = 0; j < NOUT; j = j + 1) begin : gOut
      reg orAcc;
      reg anyAsg;
      integer i;
      always @* begin
        orAcc  = 1'b0;
        anyAsg = 1'b0;
        for (i = 0; i < NMSG; i = i + 1) begin
          if (asgFlat[i*AW +: AW] == j + 1) begin
            orAcc  = orAcc | msgPol[i];
            anyAsg = 1'b1;
          end
        end
      end
      assign routed[j]   = orAcc;
      assign assigned[j] = anyAsg;
    end
  endgenerate

endmodule // cor_msg_route

// *** logic/cor_warn_timer.v ***
// Purpose: holds the serial warning indication for a fixed number of ticks
// Assumes: tick is a one-cycle enable pulse
// Notes:   a new start restarts the full period
`timescale 1ns/1ps
module cor_warn_timer #(
  parameter TICKS = 3000,
  parameter CW    = 12
) (
  input  wire clk,    // system clock
  input  wire rstn,   // synchronous reset, active low
  input  wire tick,   // periodic enable pulse
  input  wire start,  // restart the warning
  output reg  active  // warning shown
);

  reg [CW-1:0] cnt_q;

  always @(posedge clk) begin
    if (!rstn) begin
      cnt_q  <= {CW{1'b0}};
      active <= 1'b0;
    end else if (start) begin
      cnt_q  <= TICKS[CW-1:0];
      active <= 1'b1;
    end else if (tick && cnt_q != {CW{1'b0}}) begin
      cnt_q  <= cnt_q - 1'b1;
      active <= (cnt_q != {{(CW-1){1'b0}}, 1'b1});
    end
  end

endmodule // cor_warn_timer

// *** logic/cor_output_routing.v ***
// Purpose: output side of a two-channel process controller: mode messages, host/front arbitration,
//          analog offset outputs and binary output routing
// Assumes: pins pass two flip-flops; control differences, analog inputs and steps come on clk
// Notes:   registers over AXI4-Lite, one outstanding read and write
//
// Notes on behaviour
// - depth 2 or more lets the host write select commands, setpoint and manual value.
// - lock 3 blocks host front operation while no-computer-operation holds; lock 4 never.
// - host select command sets last-operation bit; front internal/manual keys clear it.
// - after host operation, first key press only warns for 3 s; second press switches.
// - controller type 12 enables channel two, selected by shift key with level indication.
// - channel two output path matches channel one but without incremental adjustment.
// - bipolar control differences leave with 50 percent offset, optionally reversed.
// - each message optionally negated and routed to one of sixteen binary outputs.
// - option slots add outputs 9-12/13-16 (four-output) or 9,10/13,14 (relay).
// - slot settings differing from fitted modules raise a configuration error.
// - step increments fixed to outputs 7 and 8 in step structures, not invertible.
// - dual type with channel two step structure 1 or 2 puts its steps on outputs 5,6.
// - messages sharing an output are ORed.
// - unassigned outputs stay low; host may set them only at depth exactly 2.
// - no-computer-standby asserts in internal operation.
// - no-computer-operation is the negated AND of internal select and computer standby.
// - manual message from front or external manual, with safety, blocking, follow-up low; the code ignores follow-up under manual priority.
// - follow-up message needs safety, blocking low, and manual low under manual priority.
// - transmitter fault is the OR of all analog range faults.
// - slave-internal message follows the slave controller internal switch.
// - channel two messages active only with dual type, same meanings.
// - analog function inputs 9-12 become 1 above 50 percent.
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "cor_regs.vh"
module cor_output_routing #(
  parameter TICK_CYCLES = `COR_TICK_US * `COR_CLK_MHZ,
  parameter NFAULT      = 4,
  parameter AIW         = 8
) (
  input  wire              clk,         // 50 MHz clock
  input  wire              rstn,        // synchronous reset, active low
  input  wire [7:0]        s_awaddr,    // write address
  input  wire              s_awvalid,   // write address valid
  output reg               s_awready,   // write address ready
  input  wire [31:0]       s_wdata,     // write data
  input  wire [3:0]        s_wstrb,     // byte enables
  input  wire              s_wvalid,    // write data valid
  output reg               s_wready,    // write data ready
  output reg  [1:0]        s_bresp,     // write response
  output reg               s_bvalid,    // write response valid
  input  wire              s_bready,    // write response ready
  input  wire [7:0]        s_araddr,    // read address
  input  wire              s_arvalid,   // read address valid
  output reg               s_arready,   // read address ready
  output reg  [31:0]       s_rdata,     // read data
  output reg  [1:0]        s_rresp,     // read response
  output reg               s_rvalid,    // read data valid
  input  wire              s_rready,    // read data ready
  input  wire              keyInt,      // front internal key pin
  input  wire              keyMan,      // front manual key pin
  input  wire              keyShift,    // front shift key pin
  input  wire              keyUp,       // front increment key pin
  input  wire              keyDn,       // front decrement key pin
  input  wire [1:0]        extManPin,   // external manual signal per channel
  input  wire [1:0]        safetyPin,   // safety signal per channel
  input  wire [1:0]        blockPin,    // blocking signal per channel
  input  wire [1:0]        followPin,   // follow-up signal per channel
  input  wire [1:0]        standbyPin,  // computer standby per channel
  input  wire              slaveIntPin, // slave controller internal switch
  input  wire [NFAULT-1:0] rangeFault,  // analog input out-of-range pins
  input  wire [1:0]        fitted5,     // module detected in slot 5
  input  wire [1:0]        fitted6,     // module detected in slot 6
  input  wire [7:0]        ctlDiff1,    // channel one control difference, signed
  input  wire [7:0]        ctlDiff2,    // channel two control difference, signed
  input  wire [1:0]        stepUp,      // positioning increment up per channel
  input  wire [1:0]        stepDn,      // positioning increment down per channel
  input  wire [4*AIW-1:0]  funcIn,      // analog function inputs 9 to 12
  output reg  [15:0]       binOut,      // binary outputs 1 to 16
  output reg  [7:0]        aOut1,       // analog output channel one
  output reg  [7:0]        aOut2,       // analog output channel two
  output reg  [15:0]       setpoint,    // internal setpoint channel one
  output reg  [15:0]       manValue1,   // manual output value channel one
  output reg  [15:0]       manValue2,   // manual output value channel two
  output reg               levelTwo,    // level II shown
  output reg               cfgError,    // slot configuration error
  output reg               warnFlash    // serial warning shown
);

  localparam [31:0] WARN_TICKS = (`COR_WARN_MS * 1000) / `COR_TICK_US;
  localparam [AIW-1:0] HALF    = {1'b1, {(AIW-1){1'b0}}};

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam NS = 20 + NFAULT;
  wire [NS-1:0] pinRaw = {rangeFault, fitted6, fitted5, slaveIntPin, standbyPin, followPin,
                          blockPin, safetyPin, extManPin, keyDn, keyUp, keyShift, keyMan, keyInt};
  reg  [NS-1:0] sync1_q;
  reg  [NS-1:0] sync2_q;
  reg  [4:0]    keyPrev_q;

  always @(posedge clk) begin
    if (!rstn) begin
      sync1_q   <= {NS{1'b0}};
      sync2_q   <= {NS{1'b0}};
      keyPrev_q <= 5'h00;
    end else begin
      sync1_q   <= pinRaw;
      sync2_q   <= sync1_q;
      keyPrev_q <= sync2_q[4:0];
    end
  end

  wire [4:0]        keyEdge  = sync2_q[4:0] & ~keyPrev_q;
  wire [1:0]        extMan   = sync2_q[6:5];
  wire [1:0]        safety   = sync2_q[8:7];
  wire [1:0]        block    = sync2_q[10:9];
  wire [1:0]        follow   = sync2_q[12:11];
  wire [1:0]        standby  = sync2_q[14:13];
  wire              slaveInt = sync2_q[15];
  wire [1:0]        fit5     = sync2_q[17:16];
  wire [1:0]        fit6     = sync2_q[19:18];
  wire [NFAULT-1:0] faults   = sync2_q[NS-1:20];

  // ----------------------------------------
  // tick divider and warning timer
  // ----------------------------------------
  reg [31:0] divCnt_q;
  reg        tick_q;

  always @(posedge clk) begin
    if (!rstn) begin
      divCnt_q <= 32'h0000_0000;
      tick_q   <= 1'b0;
    end else if (divCnt_q == TICK_CYCLES - 1) begin
      divCnt_q <= 32'h0000_0000;
      tick_q   <= 1'b1;
    end else begin
      divCnt_q <= divCnt_q + 32'h0000_0001;
      tick_q   <= 1'b0;
    end
  end

  reg  warnStart;
  wire warnActive;

  cor_warn_timer #(
    .TICKS (WARN_TICKS),
    .CW    (16)
  ) uWarn (
    .clk    (clk),
    .rstn   (rstn),
    .tick   (tick_q),
    .start  (warnStart),
    .active (warnActive)
  );

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [31:0]  cfg_q;
  reg [15:0]  inv_q;
  reg [127:0] asg_q;
  reg [15:0]  hostBo_q;
  reg [1:0]   intSel_q;
  reg [1:0]   manSel_q;
  reg         lastSerial_q;
  reg         warnPending_q;
  reg [7:0]   awAddr_q;
  reg [31:0]  wData_q;
  reg [3:0]   wStrb_q;
  reg         awHeld_q;
  reg         wHeld_q;

  wire [3:0] ctlType = cfg_q[`COR_TYPE_LSB +: 4];
  wire [1:0] outStr1 = cfg_q[`COR_STR1_LSB +: 2];
  wire [1:0] outStr2 = cfg_q[`COR_STR2_LSB +: 2];
  wire [2:0] depth   = cfg_q[`COR_DEPTH_LSB +: 3];
  wire [2:0] lockSw  = cfg_q[`COR_LOCK_LSB +: 3];
  wire [1:0] slot5   = cfg_q[`COR_SLOT5_LSB +: 2];
  wire [1:0] slot6   = cfg_q[`COR_SLOT6_LSB +: 2];
  wire       dual    = (ctlType == `COR_TYPE_DUAL);
  wire       hostCtl = (depth >= `COR_DEPTH_HOST);
  wire [1:0] noCompOp = ~(intSel_q & standby);
  wire       hostFront = hostCtl && !(lockSw == `COR_LOCK_RC && noCompOp[0]);

  wire [31:0] byteMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
  wire        doWrite  = awHeld_q && wHeld_q && !s_bvalid;
  wire [3:0]  wIdx     = awAddr_q[5:2];
  wire        wMapped  = (awAddr_q[7:6] == 2'b00) && (awAddr_q <= `COR_HOSTBO_OFF);

  function [31:0] merge;
    input [31:0] oldV;
    input [31:0] newV;
    input [31:0] mask;
    begin
      merge = (oldV & ~mask) | (newV & mask);
    end
  endfunction

  wire [31:0] invNew   = merge({16'h0000, inv_q}, wData_q, byteMask);

  wire cmdWr  = doWrite && awAddr_q == `COR_CMD_OFF && hostFront;
  wire keyIntE = keyEdge[0];
  wire keyManE = keyEdge[1];
  wire lvl     = levelTwo & dual;

  always @(posedge clk) begin
    if (!rstn) begin
      cfg_q         <= `COR_CFG_RST;
      inv_q         <= 16'h0000;
      asg_q         <= 128'h0;
      hostBo_q      <= 16'h0000;
      intSel_q      <= 2'h3;
      manSel_q      <= 2'h0;
      setpoint      <= 16'h0000;
      manValue1     <= 16'h0000;
      manValue2     <= 16'h0000;
      lastSerial_q  <= 1'b0;
      warnPending_q <= 1'b0;
      levelTwo      <= 1'b0;
      warnStart     <= 1'b0;
    end else begin
      warnStart <= 1'b0;
      if (keyEdge[2] && dual)
        levelTwo <= ~levelTwo;
      else if (!dual)
        levelTwo <= 1'b0;
      // front keys: first press after host operation only warns
      if (keyIntE || keyManE) begin
        if (lastSerial_q && !warnPending_q) begin
          warnPending_q <= 1'b1;
          warnStart     <= 1'b1;
        end else begin
          warnPending_q <= 1'b0;
          lastSerial_q  <= 1'b0;
          if (keyIntE)
            intSel_q[lvl] <= ~intSel_q[lvl];
          if (keyManE)
            manSel_q[lvl] <= ~manSel_q[lvl];
        end
      end
      // incremental manual adjustment exists on channel one only
      if (tick_q && !lvl && manSel_q[0]) begin
        if (sync2_q[3] && manValue1 != 16'hFFFF)
          manValue1 <= manValue1 + 16'h0001;
        else if (sync2_q[4] && manValue1 != 16'h0000)
          manValue1 <= manValue1 - 16'h0001;
      end
      if (doWrite && wMapped) begin
        case (wIdx)
          4'h0: cfg_q <= merge(cfg_q, wData_q, byteMask);
          4'h1: inv_q <= invNew[15:0];
          4'h2: asg_q[31:0]   <= merge(asg_q[31:0], wData_q, byteMask);
          4'h3: asg_q[63:32]  <= merge(asg_q[63:32], wData_q, byteMask);
          4'h4: asg_q[95:64]  <= merge(asg_q[95:64], wData_q, byteMask);
          4'h5: asg_q[127:96] <= merge(asg_q[127:96], wData_q, byteMask);
          4'h7: begin
            if (hostCtl) begin
              setpoint  <= wData_q[15:0];
              manValue1 <= wData_q[31:16];
            end
          end
          4'h8: begin
            if (hostCtl)
              manValue2 <= wData_q[15:0];
          end
          4'h9: hostBo_q <= wData_q[15:0];
          default: begin
          end
        endcase
      end
      // host select commands; a set here wins over a key clear above
      if (cmdWr) begin
        intSel_q[0]   <= wData_q[0];
        manSel_q[0]   <= wData_q[1];
        lastSerial_q  <= 1'b1;
        warnPending_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      s_awready <= 1'b1;
      s_wready  <= 1'b1;
      s_bvalid  <= 1'b0;
      s_bresp   <= 2'b00;
      awHeld_q  <= 1'b0;
      wHeld_q   <= 1'b0;
      awAddr_q  <= 8'h00;
      wData_q   <= 32'h0000_0000;
      wStrb_q   <= 4'h0;
    end else begin
      if (s_awready && s_awvalid) begin
        awAddr_q  <= s_awaddr;
        awHeld_q  <= 1'b1;
        s_awready <= 1'b0;
      end
      if (s_wready && s_wvalid) begin
        wData_q  <= s_wdata;
        wStrb_q  <= s_wstrb;
        wHeld_q  <= 1'b1;
        s_wready <= 1'b0;
      end
      if (doWrite) begin
        s_bvalid <= 1'b1;
        s_bresp  <= wMapped ? 2'b00 : 2'b11;
      end
      if (s_bvalid && s_bready) begin
        s_bvalid  <= 1'b0;
        awHeld_q  <= 1'b0;
        wHeld_q   <= 1'b0;
        s_awready <= 1'b1;
        s_wready  <= 1'b1;
      end
    end
  end

  reg [31:0] rdMux;
  reg        rdOk;

  always @* begin
    rdMux = 32'h0000_0000;
    rdOk  = 1'b1;
    case (s_araddr)
      `COR_CFG_OFF:    rdMux = cfg_q;
      `COR_INV_OFF:    rdMux = {16'h0000, inv_q};
      `COR_ASG0_OFF:   rdMux = asg_q[31:0];
      `COR_ASG1_OFF:   rdMux = asg_q[63:32];
      `COR_ASG2_OFF:   rdMux = asg_q[95:64];
      `COR_ASG3_OFF:   rdMux = asg_q[127:96];
      `COR_CMD_OFF:    rdMux = {30'h0, manSel_q[0], intSel_q[0]};
      `COR_VAL1_OFF:   rdMux = {manValue1, setpoint};
      `COR_VAL2_OFF:   rdMux = {16'h0000, manValue2};
      `COR_HOSTBO_OFF: rdMux = {16'h0000, hostBo_q};
      `COR_STAT_OFF:   rdMux = {binOut, 8'h00, manSel_q, intSel_q, levelTwo, cfgError,
                                warnFlash, lastSerial_q};
      default:         rdOk  = 1'b0;
    endcase
  end

  always @(posedge clk) begin
    if (!rstn) begin
      s_arready <= 1'b1;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0000_0000;
      s_rresp   <= 2'b00;
    end else if (s_arready && s_arvalid) begin
      s_rdata   <= rdMux;
      s_rresp   <= rdOk ? 2'b00 : 2'b11;
      s_rvalid  <= 1'b1;
      s_arready <= 1'b0;
    end else if (s_rvalid && s_rready) begin
      s_rvalid  <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // message signals
  // ----------------------------------------
  wire [1:0] mPrio   = {cfg_q[`COR_MPRIO2_BIT], cfg_q[`COR_MPRIO1_BIT]};
  wire [1:0] manSrc  = manSel_q | extMan;
  wire [1:0] manMsg  = manSrc & ~safety & ~block & ~(~mPrio & follow);
  wire [1:0] folMsg  = follow & ~safety & ~block & ~(mPrio & manSrc);
  wire       faultMsg = |faults;
  wire [3:0] funcMsg;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gFunc
      assign funcMsg[g] = funcIn[g*AIW +: AIW] > HALF;
    end
  endgenerate

  // second channel messages stay quiet unless dual type
  wire [4:0] ch2Msg = dual ? {1'b0, folMsg[1], manMsg[1], noCompOp[1], intSel_q[1]} : 5'h00;
  wire [15:0] msgVec = {1'b0, funcMsg, ch2Msg, slaveInt, faultMsg, folMsg[0], manMsg[0],
                        noCompOp[0], intSel_q[0]};

  wire [15:0] routed;
  wire [15:0] assigned;
  wire [79:0] asgFlat;

  generate
    for (g = 0; g < 16; g = g + 1) begin : gAsg
      assign asgFlat[g*5 +: 5] = asg_q[g*8 +: 5];
    end
  endgenerate

  cor_msg_route #(
    .NMSG (16),
    .NOUT (16),
    .AW   (5)
  ) uRoute (
    .msg      (msgVec),
    .invMask  (inv_q),
    .asgFlat  (asgFlat),
    .routed   (routed),
    .assigned (assigned)
  );

  // ----------------------------------------
  // binary and analog outputs
  // ----------------------------------------
  reg [15:0] boNext;

  always @* begin
    boNext = routed | ((depth == `COR_DEPTH_HOST) ? (hostBo_q & ~assigned) : 16'h0000);
    if (outStr1 != 2'b00) begin
      boNext[6] = stepUp[0];
      boNext[7] = stepDn[0];
    end
    if (dual && (outStr2 == 2'b01 || outStr2 == 2'b10)) begin
      boNext[4] = stepUp[1];
      boNext[5] = stepDn[1];
    end
    if (slot5 == `COR_SLOT_NONE)
      boNext[11:8] = 4'h0;
    else if (slot5 == `COR_SLOT_TWO)
      boNext[11:10] = 2'b00;
    if (slot6 == `COR_SLOT_NONE)
      boNext[15:12] = 4'h0;
    else if (slot6 == `COR_SLOT_TWO)
      boNext[15:14] = 2'b00;
  end

  // reversing -128 wraps; the converter span makes that corner harmless
  wire [7:0] diff1 = cfg_q[`COR_REV1_BIT] ? (~ctlDiff1 + 8'h01) : ctlDiff1;
  wire [7:0] diff2 = cfg_q[`COR_REV2_BIT] ? (~ctlDiff2 + 8'h01) : ctlDiff2;

  always @(posedge clk) begin
    if (!rstn) begin
      binOut    <= 16'h0000;
      aOut1     <= 8'h80;
      aOut2     <= 8'h80;
      cfgError  <= 1'b0;
      warnFlash <= 1'b0;
    end else begin
      binOut    <= boNext;
      aOut1     <= diff1 ^ 8'h80;
      aOut2     <= dual ? (diff2 ^ 8'h80) : 8'h80;
      cfgError  <= (slot5 != fit5) || (slot6 != fit6);
      warnFlash <= warnActive;
    end
  end

endmodule // cor_output_routing

// *** tb/cor_output_routing_assertions.sv ***
// Purpose: register bus checks at the top ports. Assumes: one clock. Notes: bound below
`timescale 1ns/1ps
module cor_output_routing_checker (
  input wire logic        clk, rstn, s_awvalid, s_awready, s_wvalid, s_wready,
  input wire logic        s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready,
  input wire logic [1:0]  s_bresp, s_rresp,
  input wire logic [31:0] s_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  b_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp)) else $error("bresp lost");
  r_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata)) else $error("rdata lost");
  w_answer_a: assert property (s_awvalid && s_awready && s_wvalid && s_wready |-> ##[1:2] s_bvalid)
    else $error("no write answer");
  r_answer_a: assert property (s_arvalid && s_arready |=> s_rvalid) else $error("no read answer");
  w_busy_a: assert property (s_bvalid |-> !s_awready && !s_wready) else $error("write taken early");
  r_busy_a: assert property (s_rvalid |-> !s_arready) else $error("read taken early");
  b_code_a: assert property (s_bvalid |-> s_bresp == 2'h0 || s_bresp == 2'h3) else $error("bad bresp");
  r_unmapped_a: assert property (s_rvalid && s_rresp == 2'h3 |-> s_rdata == 32'h0) else $error("rdata");
endmodule // cor_output_routing_checker
bind cor_output_routing cor_output_routing_checker chk_u (.clk, .rstn, .s_awvalid, .s_awready, .s_wvalid,
  .s_wready, .s_bvalid, .s_bready, .s_arvalid, .s_arready, .s_rvalid, .s_rready, .s_bresp, .s_rresp, .s_rdata);

// *** tb/cor_host_model.sv ***
// Purpose: host bus master. Assumes: AXI4-Lite, one access at a time. Notes: waits without bound
`timescale 1ns/1ps
module cor_host_model (
  input wire logic        clk, s_awready, s_wready, s_bvalid, s_arready, s_rvalid,
  input wire logic [1:0]  s_bresp, s_rresp,
  input wire logic [31:0] s_rdata,
  output logic [7:0]      s_awaddr = 8'h00, s_araddr = 8'h00,
  output logic [31:0]     s_wdata = 32'h0,
  output logic            s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0, s_arvalid = 1'h0, s_rready = 1'h0
);
  // host writes commands and values; the device decides what it accepts
  task automatic wr(input [7:0] a, input [31:0] d, output [1:0] r);
    logic ta, tw;
    ta = 0;
    tw = 0;
    @(posedge clk);
    s_awaddr <= a;
    s_wdata <= d;
    {s_awvalid, s_wvalid, s_bready} <= 3'h7;
    while (!(ta && tw)) begin
      @(posedge clk);
      if (s_awready && !ta) begin ta = 1; s_awvalid <= 0; end
      if (s_wready && !tw) begin tw = 1; s_wvalid <= 0; end
    end
    do @(posedge clk); while (!s_bvalid);
    r = s_bresp;
    s_bready <= 0;
  endtask
  task automatic rd(input [7:0] a, output [31:0] d, output [1:0] r);
    @(posedge clk);
    s_araddr <= a;
    {s_arvalid, s_rready} <= 2'h3;
    do @(posedge clk); while (!s_arready);
    s_arvalid <= 0;
    do @(posedge clk); while (!s_rvalid);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 0;
  endtask
endmodule // cor_host_model

// *** tb/cor_output_routing_bench.sv ***
// Purpose: self-checking bench. Assumes: tick of 2 cycles. Notes: expectations worked out inline
`timescale 1ns/1ps
`include "cor_regs.vh"
module cor_output_routing_bench;
  logic        clk = 0, rstn = 0, keyInt = 0, keyMan = 0, slaveIntPin = 0, keyShift = 0, keyUp = 0, keyDn = 0;
  logic [1:0]  extManPin = 0, safetyPin = 0, blockPin = 0, followPin = 0, stepUp = 0, stepDn = 0, r;
  logic [1:0]  fitted5 = 1, fitted6 = 1, standbyPin = 0, s_bresp, s_rresp;
  logic [3:0]  rangeFault = 0;
  logic [7:0]  ctlDiff1 = 0, ctlDiff2 = 0, s_awaddr, s_araddr, aOut1, aOut2;
  logic [31:0] funcIn = 0, s_wdata, s_rdata, seed = 32'h1938A590, rs = 32'h1938A590, d;
  logic [15:0] binOut, ex, setpoint;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready, s_arvalid, s_arready;
  logic        s_rvalid, s_rready, levelTwo, cfgError, warnFlash;
  integer      errors = 0, checks = 0, i;
  cor_output_routing #(.TICK_CYCLES(2)) dut_u (.clk, .rstn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
    .s_wstrb(4'hF), .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .keyInt, .keyMan, .keyShift, .keyUp, .keyDn, .extManPin,
    .safetyPin, .blockPin, .followPin, .standbyPin, .slaveIntPin, .rangeFault, .fitted5, .fitted6,
    .ctlDiff1, .ctlDiff2, .stepUp, .stepDn, .funcIn, .binOut, .aOut1, .aOut2, .setpoint, .manValue1(),
    .manValue2(), .levelTwo, .cfgError, .warnFlash);
  cor_host_model host_u (.clk, .s_awready, .s_wready, .s_bvalid, .s_arready, .s_rvalid, .s_bresp, .s_rresp,
    .s_rdata, .s_awaddr, .s_araddr, .s_wdata, .s_awvalid, .s_wvalid, .s_bready, .s_arvalid, .s_rready);
  function automatic [31:0] xs(input [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    xs = v ^ (v << 5);
  endfunction
  function automatic [31:0] cfg(input integer dp, lk, s6, rv);
    cfg = dp << 8 | lk << 11 | 1 << 14 | s6 << 16 | rv << 20;
  endfunction
  task chk(input [33:0] s, e);
    checks++;
    if (s !== e) begin errors++; $display("mismatch t=%0t seen=%h exp=%h", $time, s, e); end
  endtask
  task complete_run;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task press(input m);
    {keyMan, keyInt} <= m ? 2'h2 : 2'h1;
    repeat (4) @(posedge clk);
    {keyMan, keyInt} <= 2'h0;
    repeat (8) @(posedge clk);
  endtask
  always #10 clk = ~clk;
  // pins nobody routes still toggle so stray coupling into the outputs shows up
  always @(posedge clk) begin
    rs = xs(rs);
    {extManPin, safetyPin, blockPin, followPin, slaveIntPin, stepUp, stepDn, keyShift, keyUp, keyDn} <= rs[15:0];
    ctlDiff2 <= rs[31:24];
  end
  initial begin #800000; errors++; complete_run; end
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1;
    host_u.rd(`COR_CFG_OFF, d, r); chk(d, `COR_CFG_RST);
    host_u.rd(8'h3C, d, r); chk({r, d}, {2'h3, 32'h0});
    host_u.wr(8'h40, 32'h1, r); chk(r, 2'h3);
    host_u.wr(`COR_ASG1_OFF, 32'h0A, r);
    host_u.wr(`COR_ASG2_OFF, 32'h0A000000, r);
    host_u.wr(`COR_ASG3_OFF, 32'h100D0C0B, r);
    host_u.wr(`COR_INV_OFF, 32'h8000, r);
    host_u.wr(`COR_HOSTBO_OFF, 32'h3, r);
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      funcIn <= i == 0 ? 32'h7F808180 : seed;
      rangeFault <= i == 0 ? 4'h0 : seed[3:0];
      ctlDiff1 <= i == 3 ? 8'h80 : seed[15:8];
      host_u.wr(`COR_CFG_OFF, cfg(2, 4, 1, i % 2), r);
      repeat (8) @(posedge clk);
      ex = 16'h8003;
      ex[9] = |rangeFault | (funcIn[7:0] > 8'h80);
      for (int k = 1; k < 4; k++) ex[9 + k] = funcIn[8 * k +: 8] > 8'h80;
      chk(binOut, ex);
      d[7:0] = (i % 2 ? 8'h0 - ctlDiff1 : ctlDiff1) + 8'h80;
      chk(aOut1, d[7:0]);
      chk(aOut2, 8'h80);
    end
    host_u.wr(`COR_CFG_OFF, cfg(3, 4, 2, 0), r);
    repeat (8) @(posedge clk);
    chk(cfgError, 1);
    chk(binOut, ex & 16'h1F00);
    host_u.wr(`COR_CFG_OFF, cfg(2, 4, 1, 0), r);
    host_u.wr(`COR_VAL1_OFF, 32'h1234ABCD, r);
    chk(setpoint, 16'hABCD);
    host_u.wr(`COR_CMD_OFF, 32'h1, r);
    host_u.rd(`COR_STAT_OFF, d, r); chk(d[0], 1);
    press(0);
    host_u.rd(`COR_STAT_OFF, d, r); chk(d[5:0], 6'h33);
    press(1);
    host_u.rd(`COR_STAT_OFF, d, r); chk(d[7:0], 8'h72);
    repeat (5850) @(posedge clk);
    chk(warnFlash, 1);
    repeat (300) @(posedge clk);
    chk(warnFlash, 0);
    for (i = 0; i < 3; i++) begin
      standbyPin <= {1'b0, i == 2};
      host_u.wr(`COR_CFG_OFF, cfg(i ? 2 : 1, i ? 3 : 4, 1, 0), r);
      host_u.wr(`COR_CMD_OFF, 32'h1, r);
      host_u.rd(`COR_STAT_OFF, d, r); chk(d[0], i == 2);
    end
    complete_run;
  end
endmodule // cor_output_routing_bench
